/* src/eeprom_pe_pkg.sv */
/*
  shared definitions for the eeprom program/erase controller: register indices,
  field positions, reset values, cycle counts and the carrier types.
  assumes a 32-bit avalon-mm slave where the byte address is four times the index.
*/
package eeprom_pe_pkg;

  // register indices (byte address = index * 4)
  localparam logic [14:0] IDX_EE_CONTROL = 15'h0007;  // eeprom_control
  localparam logic [14:0] IDX_EE_BASE = 15'h0100;     // first eeprom byte, also nonvolatile_options
  localparam logic [14:0] IDX_EE_LAST = 15'h01ff;     // last eeprom byte
  localparam logic [14:0] IDX_FACTORY_OPTS = 15'h7fde; // factory_option_bits
  localparam int ADDR_W = 17;                          // byte address width

  // eeprom geometry
  localparam logic [7:0] LOWER_REGION_BYTES = 8'h20;   // 32 always-writable bytes
  localparam logic [7:0] ERASED_BYTE = 8'hff;          // value of an erased cell

  // eeprom_control field positions
  localparam int POS_PUMP = 0;
  localparam int POS_LATCH = 1;
  localparam int POS_ERASE = 2;
  localparam logic [7:0] EE_CONTROL_RESET = 8'h00;     // bits 7:3 undefined, read zero

  // nonvolatile_options field positions
  localparam int POS_SECURITY = 0;
  localparam int POS_UNPROTECT = 1;

  // factory_option_bits field positions
  localparam int POS_PC_PULLDOWN = 0;
  localparam int POS_PB_PULLDOWN = 1;
  localparam int POS_WD_IN_WAIT = 2;
  localparam int POS_WD_AFTER_RESET = 3;
  localparam int POS_RESET_HOLD_SEL = 4;

  // reset-pin hold after reset, in cycles
  localparam logic [11:0] HOLD_SHORT_CYC = 12'd16;
  localparam logic [11:0] HOLD_LONG_CYC = 12'd4064;

  // control state as {erase_select, write_latch_enable, pump_enable}
  typedef enum logic [2:0] {
    ST_READ = 3'b000,
    ST_LOAD = 3'b010,
    ST_PROGRAM = 3'b011,
    ST_ERASE_ADDR = 3'b110,
    ST_ERASING = 3'b111
  } ee_state_t;

  // captured target of a pending program or erase
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } ee_target_t;

endpackage

/* src/eeprom_program_erase_ctl.sv */
/*
  eeprom program/erase controller with protection, security and factory options.
  holds a 256-byte eeprom as flip-flops (nonvolatile: not touched by reset),
  the control register, and the option decoding that reset samples.
  assumes an avalon-mm master on sys_clk, and stop/wait/bootstrap/port-direction
  signals produced by logic on the same clock.
*/
// Design decision made here: register access over Avalon-MM.
module eeprom_program_erase_ctl
  import eeprom_pe_pkg::*;
#(
  parameter logic [7:0] FACTORY_OPTIONS = 8'h00  // mask-option content
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // system mode inputs
  input wire logic stopEntry,
  input wire logic waitMode,
  input wire logic bootstrapMode,
  input wire logic nonUserModeReq,
  input wire logic [7:0] portBIsOutput,
  input wire logic [7:0] portCIsOutput,
  // controlled outputs
  output logic pumpOn,
  output logic highVoltageOn,
  output logic resetPinLow,
  output logic watchdogRun,
  output logic nonUserModeGrant,
  output logic [7:0] portBPulldown,
  output logic [7:0] portCPulldown
);

  // eeprom cells; erased at power-up, no reset so contents survive resets.
  // the power-up value sits in the declaration so the array keeps a single writer
  logic [7:0] eeMem [256] = '{default: ERASED_BYTE};
  // control state {erase_select, write_latch_enable, pump_enable}
  ee_state_t ctrlState_q;
  // pending target captured while loading
  ee_target_t target_q;
  // bus answer flag: high in the cycle the request completes
  logic busAck_q;
  logic [31:0] readData_q;
  // reset-time snapshots of option bits, then the hold counter and registered outputs
  logic postReset_q;
  logic unprotLatched_q;
  logic secLatched_q;
  logic wdArmed_q;
  logic [11:0] holdCnt_q;
  logic resetPinLow_q;
  logic watchdogRun_q;
  logic grant_q;
  logic [7:0] pdB_q;
  logic [7:0] pdC_q;

  // decoded strobes
  logic [14:0] regIdx;
  logic wrTake;
  logic wrCtrl;
  logic wrEe;
  logic [7:0] eeOff;
  logic upperProtected;
  logic pumpRise;
  logic opAllowed;
  ee_state_t ctrlState_d;

  // is this index inside the eeprom window
  function automatic logic in_eeprom(input logic [14:0] idx);
    in_eeprom = (idx >= IDX_EE_BASE) && (idx <= IDX_EE_LAST);
  endfunction

  // offset within eeprom falls into the guarded upper region
  function automatic logic is_upper(input logic [7:0] off);
    is_upper = (off >= LOWER_REGION_BYTES);
  endfunction

  assign regIdx = avs_address[ADDR_W-1:2];
  assign eeOff = regIdx[7:0];
  // a write lands only at the completing edge and only with the low lane enabled
  assign wrTake = busAck_q && avs_write && avs_byteenable[0];
  assign wrCtrl = wrTake && (regIdx == IDX_EE_CONTROL);
  assign wrEe = wrTake && in_eeprom(regIdx);

  // every request waits exactly one cycle; keeps read data registered
  assign avs_waitrequest = (avs_read || avs_write) && !busAck_q;
  assign avs_readdata = readData_q;

  // bus handshake: one wait state per request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busAck_q <= 1'b0;
    end else begin
      busAck_q <= (avs_read || avs_write) && !busAck_q;
    end
  end

  // read mux, sampled in the wait cycle so data stands at the completing edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      readData_q <= 32'h0000_0000;
    end else if (avs_read && !busAck_q) begin
      if (regIdx == IDX_EE_CONTROL) begin
        readData_q <= {29'h0000_0000, ctrlState_q};
      end else if (regIdx == IDX_FACTORY_OPTS) begin
        readData_q <= {24'h00_0000, FACTORY_OPTIONS};
      end else if (in_eeprom(regIdx)) begin
        // array content is meaningless while latched, so answer zero then
        readData_q <= (ctrlState_q[POS_LATCH]) ? 32'h0000_0000 :
                      {24'h00_0000, eeMem[eeOff]};
      end else begin
        readData_q <= 32'h0000_0000;  // unmapped reads as zero
      end
    end
  end

  // next control state from software writes and stop entry
  always_comb begin
    ctrlState_d = ctrlState_q;
    if (stopEntry) begin
      ctrlState_d = ST_READ;
    end else if (wrCtrl) begin
      if (!avs_writedata[POS_LATCH]) begin
        ctrlState_d = ST_READ;
      end else begin
        case (ctrlState_q)
          ST_READ: begin
            // entering load or erase address; pump cannot come on in the same write
            ctrlState_d = avs_writedata[POS_ERASE] ? ST_ERASE_ADDR : ST_LOAD;
          end
          ST_LOAD, ST_ERASE_ADDR: begin
            if (target_q.valid && avs_writedata[POS_PUMP]) begin
              ctrlState_d = ctrlState_q[POS_ERASE] ? ST_ERASING : ST_PROGRAM;
            end else if (target_q.valid) begin
              ctrlState_d = ctrlState_q;
            end else begin
              ctrlState_d = avs_writedata[POS_ERASE] ? ST_ERASE_ADDR : ST_LOAD;
            end
          end
          ST_PROGRAM, ST_ERASING: begin
            ctrlState_d = ctrlState_q;
          end
          default: begin
            ctrlState_d = ST_READ;
          end
        endcase
      end
    end
  end

  // control register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlState_q <= ee_state_t'(EE_CONTROL_RESET[2:0]);
    end else begin
      ctrlState_q <= ctrlState_d;
    end
  end

  // target capture: a write to the array while loading is latched, not stored
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      target_q <= '0;
    end else if (ctrlState_d == ST_READ) begin
      target_q <= '0;
    end else if (wrEe && !ctrlState_q[POS_PUMP] && ctrlState_q[POS_LATCH]) begin
      if (!target_q.valid) begin
        target_q.valid <= 1'b1;
        target_q.addr <= eeOff;
        target_q.data <= avs_writedata[7:0];
      end else if (!ctrlState_q[POS_ERASE]) begin
        target_q.data <= avs_writedata[7:0];  // later data to the same load replaces it
      end
    end
  end

  // the live unprotect bit can only close protection before the next reset
  assign upperProtected = !bootstrapMode &&
                          !(unprotLatched_q && eeMem[0][POS_UNPROTECT]);
  assign pumpRise = ctrlState_d[POS_PUMP] && !ctrlState_q[POS_PUMP];
  assign opAllowed = !(is_upper(target_q.addr) && upperProtected);

  // array update at the moment the pump comes on
  always_ff @(posedge sys_clk) begin
    if (pumpRise && opAllowed) begin
      if (ctrlState_d[POS_ERASE]) begin
        eeMem[target_q.addr] <= ERASED_BYTE;
      end else begin
        // options byte included: its bits only change here, i.e. with latch set
        eeMem[target_q.addr] <= target_q.data;
      end
    end
  end

  // charge pump and high voltage follow the pump bit
  assign pumpOn = ctrlState_q[POS_PUMP];
  assign highVoltageOn = ctrlState_q[POS_PUMP];

  // snapshots taken on the first edge after reset release
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      postReset_q <= 1'b0;
      unprotLatched_q <= 1'b0;
      secLatched_q <= 1'b0;
      wdArmed_q <= 1'b0;
    end else if (!postReset_q) begin
      postReset_q <= 1'b1;
      unprotLatched_q <= eeMem[0][POS_UNPROTECT];
      secLatched_q <= eeMem[0][POS_SECURITY];
      wdArmed_q <= FACTORY_OPTIONS[POS_WD_AFTER_RESET] && !bootstrapMode;
    end
  end

  // reset-pin hold counter; long hold stays under the parameter threshold
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      holdCnt_q <= 12'h000;
      resetPinLow_q <= 1'b1;
    end else if (resetPinLow_q) begin
      if (holdCnt_q == (FACTORY_OPTIONS[POS_RESET_HOLD_SEL] ? HOLD_SHORT_CYC : HOLD_LONG_CYC)
          - 12'd1) begin
        resetPinLow_q <= 1'b0;
      end else begin
        holdCnt_q <= holdCnt_q + 12'd1;
      end
    end
  end
  assign resetPinLow = resetPinLow_q;

  // watchdog run, mode grant and pull-downs, registered
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdogRun_q <= 1'b0;
      grant_q <= 1'b0;
      pdB_q <= 8'h00;
      pdC_q <= 8'h00;
    end else begin
      watchdogRun_q <= wdArmed_q && (!waitMode || FACTORY_OPTIONS[POS_WD_IN_WAIT]);
      grant_q <= nonUserModeReq && secLatched_q;
      pdB_q <= {8{FACTORY_OPTIONS[POS_PB_PULLDOWN]}} & ~portBIsOutput;
      pdC_q <= {8{FACTORY_OPTIONS[POS_PC_PULLDOWN]}} & ~portCIsOutput;
    end
  end
  assign watchdogRun = watchdogRun_q;
  assign nonUserModeGrant = grant_q;
  assign portBPulldown = pdB_q;
  assign portCPulldown = pdC_q;

  // assertions
  property p_latch_clears_all;
    @(posedge sys_clk) disable iff (!rst_b)
      !ctrlState_q[POS_LATCH] |-> (ctrlState_q == ST_READ);
  endproperty
  a_latch_clears_all: assert property (p_latch_clears_all)
    else $error("erase or pump set without latch");

  property p_stop_clears;
    @(posedge sys_clk) disable iff (!rst_b)
      stopEntry |=> (ctrlState_q == ST_READ);
  endproperty
  a_stop_clears: assert property (p_stop_clears)
    else $error("stop entry did not clear control");

  property p_pump_needs_target;
    @(posedge sys_clk) disable iff (!rst_b)
      $rose(ctrlState_q[POS_PUMP]) |-> $past(target_q.valid);
  endproperty
  a_pump_needs_target: assert property (p_pump_needs_target)
    else $error("pump set before target capture");

  property p_pump_sticky;
    @(posedge sys_clk) disable iff (!rst_b)
      (ctrlState_q[POS_PUMP] && !stopEntry && !(wrCtrl && !avs_writedata[POS_LATCH]))
      |=> ctrlState_q[POS_PUMP];
  endproperty
  a_pump_sticky: assert property (p_pump_sticky)
    else $error("pump cleared without clearing latch");

  property p_erase_frozen;
    @(posedge sys_clk) disable iff (!rst_b)
      (target_q.valid && ctrlState_q[POS_LATCH] && ctrlState_d[POS_LATCH])
      |-> (ctrlState_d[POS_ERASE] == ctrlState_q[POS_ERASE]);
  endproperty
  a_erase_frozen: assert property (p_erase_frozen)
    else $error("erase select changed after capture");

  property p_legal_state;
    @(posedge sys_clk) disable iff (!rst_b)
      ctrlState_q inside {ST_READ, ST_LOAD, ST_PROGRAM, ST_ERASE_ADDR, ST_ERASING};
  endproperty
  a_legal_state: assert property (p_legal_state)
    else $error("illegal control state");

  property p_protected_upper;
    @(posedge sys_clk) disable iff (!rst_b)
      (pumpRise && upperProtected && is_upper(target_q.addr))
      |=> (eeMem[$past(target_q.addr)] == $past(eeMem[target_q.addr]));
  endproperty
  a_protected_upper: assert property (p_protected_upper)
    else $error("protected cell was changed");

  property p_grant_secure;
    @(posedge sys_clk) disable iff (!rst_b)
      grant_q |-> (secLatched_q && $past(nonUserModeReq));
  endproperty
  a_grant_secure: assert property (p_grant_secure)
    else $error("non-user mode granted while secured");

  property p_hold_short;
    @(posedge sys_clk) disable iff (!rst_b)
      (FACTORY_OPTIONS[POS_RESET_HOLD_SEL] && $rose(postReset_q)) |-> resetPinLow_q [*8]
      ##1 resetPinLow_q [*7] ##1 !resetPinLow_q;
  endproperty
  a_hold_short: assert property (p_hold_short)
    else $error("short reset hold length wrong");

  property p_pulldown_outputs;
    @(posedge sys_clk) disable iff (!rst_b)
      ##1 ((pdB_q & $past(portBIsOutput)) == 8'h00);
  endproperty
  a_pulldown_outputs: assert property (p_pulldown_outputs)
    else $error("pull-down on an output pin");

  // a single control write out of the read state must never start the pump
  property p_no_pump_from_read;
    @(posedge sys_clk) disable iff (!rst_b)
      (ctrlState_q == ST_READ) |=> !ctrlState_q[POS_PUMP];
  endproperty
  a_no_pump_from_read: assert property (p_no_pump_from_read)
    else $error("pump set straight from read state");

  // the security snapshot may only move at the first edge after reset
  property p_security_held;
    @(posedge sys_clk) disable iff (!rst_b)
      (postReset_q && $past(postReset_q)) |-> $stable(secLatched_q);
  endproperty
  a_security_held: assert property (p_security_held)
    else $error("security snapshot changed between resets");

  c_program: cover property (@(posedge sys_clk) disable iff (!rst_b)
    ctrlState_q == ST_LOAD ##[1:20] ctrlState_q == ST_PROGRAM);
  c_erase: cover property (@(posedge sys_clk) disable iff (!rst_b)
    ctrlState_q == ST_ERASE_ADDR ##[1:20] ctrlState_q == ST_ERASING);
  c_stop_abort: cover property (@(posedge sys_clk) disable iff (!rst_b)
    ctrlState_q[POS_PUMP] && stopEntry);
  c_blocked: cover property (@(posedge sys_clk) disable iff (!rst_b)
    pumpRise && !opAllowed);

endmodule

/* dv/tb_top.sv */
/*
  self-checking bench for the eeprom program/erase controller.
  assumes the controller's one-wait-state avalon-mm slave, a 25 MHz sys_clk and
  the factory options fixed by parameter (short reset hold, both watchdog bits,
  both pull-down bits set).
*/
module tb_top
  import eeprom_pe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] OPTS = 8'h1f;  // factory option content under test
  localparam logic [16:0] CA = {IDX_EE_CONTROL, 2'b00};  // control register address

  // clock, reset and bus master signals
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // mode and pin inputs
  logic stopEntry = 1'b0;
  logic waitMode = 1'b0;
  logic bootstrapMode = 1'b0;
  logic nonUserModeReq = 1'b0;
  logic [7:0] portBIsOutput = 8'h00;
  logic [7:0] portCIsOutput = 8'h00;
  // observed outputs
  logic pumpOn, highVoltageOn, resetPinLow, watchdogRun, nonUserModeGrant;
  logic [7:0] portBPulldown, portCPulldown;
  int miscompares = 0;  // mismatches seen
  int tests_run = 0;  // comparisons made

  eeprom_program_erase_ctl #(.FACTORY_OPTIONS(OPTS)) u_eeprom_program_erase_ctl (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stopEntry(stopEntry),
    .waitMode(waitMode), .bootstrapMode(bootstrapMode), .nonUserModeReq(nonUserModeReq),
    .portBIsOutput(portBIsOutput), .portCIsOutput(portCIsOutput), .pumpOn(pumpOn),
    .highVoltageOn(highVoltageOn), .resetPinLow(resetPinLow), .watchdogRun(watchdogRun),
    .nonUserModeGrant(nonUserModeGrant), .portBPulldown(portBPulldown),
    .portCPulldown(portCPulldown));

  // 40 ns period
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  // byte address of an eeprom cell by its offset
  function automatic logic [16:0] ea(input logic [7:0] off);
    return {IDX_EE_BASE + {7'h00, off}, 2'b00};
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one bus cycle; waitrequest and readdata are sampled at the rising edge itself
  task automatic bus(input logic wr, input logic [16:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [7:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata[7:0];
    if (n >= 50) chk("bus answer", 0, 1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // one idle edge so the next request is never assigned in the same step
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, 4'h1, q);
  endtask

  task automatic rchk(input string nm, input logic [16:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, 4'h1, q);
    chk(nm, {24'h0, q}, {24'h0, e});
  endtask

  // full program (er=0) or erase (er=1) of one cell, ended by software
  task automatic prog(input logic [16:0] a, input logic [7:0] d, input logic er);
    wr(CA, {5'h0, er, 2'b10});
    wr(a, d);
    wr(CA, {5'h0, er, 2'b11});
    wr(CA, 8'h00);
  endtask

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
  endtask

  task automatic t_reset();
    int n;
    rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    n = 0;
    // count edges until the reset pin is let go
    forever begin
      @(negedge sys_clk);
      if (resetPinLow !== 1'b1 || n > 5000) break;
      n++;
      @(posedge sys_clk);
    end
    @(posedge sys_clk);
    chk("hold cycles", (n >= 16 && n <= 17), 1);
    chk("watchdog after reset", watchdogRun, 1'b1);
    rchk("ctrl reset", CA, EE_CONTROL_RESET);
    rchk("factory", {IDX_FACTORY_OPTS, 2'b00}, OPTS);
    wr({IDX_FACTORY_OPTS, 2'b00}, 8'h00);
    rchk("factory ro", {IDX_FACTORY_OPTS, 2'b00}, OPTS);
    rchk("unmapped", 17'h00040, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_program();
    wr(CA, 8'h02);
    rchk("ctrl load", CA, 8'h02);
    rchk("read latched", ea(8'h01), 8'h00);
    wr(ea(8'h01), 8'h5a);
    wr(CA, 8'h03);
    @(negedge sys_clk);
    chk("pump on", {pumpOn, highVoltageOn}, 2'b11);
    @(posedge sys_clk);
    rchk("ctrl prog", CA, 8'h03);
    wr(CA, 8'h02);
    rchk("pump sticky", CA, 8'h03);
    wr(CA, 8'h00);
    @(negedge sys_clk);
    chk("pump off", {pumpOn, highVoltageOn}, 2'b00);
    @(posedge sys_clk);
    rchk("programmed", ea(8'h01), 8'h5a);
    $display("test program done");
  endtask

  task automatic t_erase();
    prog(ea(8'h02), 8'h11, 1'b0);
    wr(CA, 8'h06);
    wr(ea(8'h02), 8'h00);
    wr(CA, 8'h02);
    rchk("erase frozen", CA, 8'h06);
    wr(CA, 8'h07);
    rchk("ctrl erasing", CA, 8'h07);
    wr(CA, 8'h00);
    rchk("erased", ea(8'h02), ERASED_BYTE);
    $display("test erase done");
  endtask

  task automatic t_illegal();
    logic [7:0] q;
    wr(CA, 8'h03);
    rchk("pump with latch", CA, 8'h02);
    wr(CA, 8'h03);
    rchk("pump before data", CA, 8'h02);
    wr(CA, 8'h00);
    wr(CA, 8'h05);
    rchk("latch clear forces", CA, 8'h00);
    bus(1'b1, CA, 8'h02, 4'h0, q);
    rchk("byteenable off", CA, 8'h00);
    $display("test illegal done");
  endtask

  task automatic t_stop();
    wr(CA, 8'h02);
    wr(ea(8'h03), 8'h22);
    wr(CA, 8'h03);
    stopEntry <= 1'b1;
    @(posedge sys_clk);
    stopEntry <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("stop pump", pumpOn, 1'b0);
    @(posedge sys_clk);
    rchk("stop ctrl", CA, 8'h00);
    wr(CA, 8'h06);
    do_reset();
    rchk("reset ctrl", CA, 8'h00);
    $display("test stop done");
  endtask

  task automatic t_pins();
    waitMode <= 1'b1;
    portBIsOutput <= 8'h0f;
    portCIsOutput <= 8'h3c;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("watchdog wait", watchdogRun, 1'b1);
    chk("pulldown b", portBPulldown, 8'hf0);
    chk("pulldown c", portCPulldown, 8'hc3);
    @(posedge sys_clk);
    waitMode <= 1'b0;
    $display("test pins done");
  endtask

  task automatic t_protect();
    nonUserModeReq <= 1'b1;
    prog(ea(8'h20), 8'h33, 1'b0);
    rchk("upper open", ea(8'h20), 8'h33);
    prog(ea(8'h00), 8'hfc, 1'b0);
    rchk("options", ea(8'h00), 8'hfc);
    wr(ea(8'h00), 8'hff);
    rchk("options no latch", ea(8'h00), 8'hfc);
    chk("grant before reset", nonUserModeGrant, 1'b1);
    prog(ea(8'h20), 8'h44, 1'b0);
    rchk("upper locked", ea(8'h20), 8'h33);
    prog(ea(8'h1f), 8'h44, 1'b0);
    rchk("lower free", ea(8'h1f), 8'h44);
    bootstrapMode <= 1'b1;
    prog(ea(8'h20), 8'h66, 1'b0);
    rchk("bootstrap open", ea(8'h20), 8'h66);
    bootstrapMode <= 1'b0;
    do_reset();
    prog(ea(8'h00), 8'h00, 1'b1);
    chk("grant secured", nonUserModeGrant, 1'b0);
    prog(ea(8'h20), 8'h77, 1'b0);
    rchk("lock held", ea(8'h20), 8'h66);
    do_reset();
    prog(ea(8'h20), 8'h77, 1'b0);
    rchk("unlocked", ea(8'h20), 8'h77);
    chk("grant open", nonUserModeGrant, 1'b1);
    bootstrapMode <= 1'b1;
    do_reset();
    repeat (2) @(posedge sys_clk);
    chk("watchdog bootstrap", watchdogRun, 1'b0);
    bootstrapMode <= 1'b0;
    $display("test protect done");
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    t_reset();
    t_program();
    t_erase();
    t_illegal();
    t_stop();
    t_pins();
    t_protect();
    results();
  end

  // watchdog: the whole run is well under 2000 cycles
  initial begin
    #400000;
    miscompares++;
    results();
  end
endmodule
